// ==== verilog/masb_pkg.sv ====
package masb_pkg;

  // register byte offsets
  localparam logic [7:0] MASB_OFF_FEATURE  = 8'h00;
  localparam logic [7:0] MASB_OFF_SECCNT   = 8'h04;
  localparam logic [7:0] MASB_OFF_SECNUM   = 8'h08;
  localparam logic [7:0] MASB_OFF_CYLLO    = 8'h0c;
  localparam logic [7:0] MASB_OFF_CYLHI    = 8'h10;
  localparam logic [7:0] MASB_OFF_DEVHEAD  = 8'h14;
  localparam logic [7:0] MASB_OFF_COMMAND  = 8'h18;
  localparam logic [7:0] MASB_OFF_DATA     = 8'h1c;
  localparam logic [7:0] MASB_OFF_ERROR    = 8'h20;
  localparam logic [7:0] MASB_OFF_STATUS   = 8'h24;
  localparam logic [7:0] MASB_OFF_INTSTAT  = 8'h28;
  localparam logic [7:0] MASB_OFF_INTMASK  = 8'h2c;
  localparam logic [7:0] MASB_OFF_MULTI    = 8'h30;
  localparam logic [7:0] MASB_OFF_SECSTATE = 8'h34;

  // command and subcommand codes
  localparam logic [7:0] MASB_CMD_NATIVE   = 8'hf8;
  localparam logic [7:0] MASB_CMD_SETMAX   = 8'hf9;
  localparam logic [7:0] MASB_CMD_SETMULTI = 8'hc6;
  localparam logic [7:0] MASB_FT_PASSWORD  = 8'h01;
  localparam logic [7:0] MASB_FT_LOCK      = 8'h02;
  localparam logic [7:0] MASB_FT_UNLOCK    = 8'h03;
  localparam logic [7:0] MASB_FT_FREEZE    = 8'h04;

  // field positions
  localparam int MASB_ERR_ABORT_BIT = 2;
  localparam int MASB_ST_BUSY_BIT   = 7;
  localparam int MASB_ST_READY_BIT  = 6;
  localparam int MASB_ST_DRQ_BIT    = 3;
  localparam int MASB_ST_ERR_BIT    = 0;
  localparam int MASB_DH_LBA_BIT    = 6;
  localparam int MASB_INT_DONE_BIT  = 0;
  localparam int MASB_INT_ABORT_BIT = 1;

  // counts and reset values
  localparam logic [2:0]  MASB_UNLOCK_TRIES = 3'h5;
  localparam logic [7:0]  MASB_SECTOR_WORDS = 8'hff;  // last word index
  localparam logic [7:0]  MASB_PW_FIRST     = 8'h01;
  localparam logic [7:0]  MASB_PW_LAST      = 8'h10;
  localparam int          MASB_PW_WORDS     = 16;
  localparam logic [27:0] MASB_NATIVE_MAX   = 28'h3ffffff;
  localparam logic [1:0]  MASB_INT_RESET    = 2'h0;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] devhead;
  } masb_taskfile_t;

  typedef struct packed {
    logic       frozen;
    logic       locked;
    logic [2:0] tries;
  } masb_secstate_t;

  typedef enum logic [1:0] {MASB_IDLE, MASB_EXEC, MASB_XFER, MASB_FIN} masb_state_t;

endpackage

// ==== verilog/masb_top.sv ====
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module masb_top
  import masb_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // interrupt
  output logic             IRQ
);
  import masb_pkg::*;

  masb_state_t    state_r;
  masb_taskfile_t tf_r;
  masb_secstate_t sec_r;
  logic [7:0]     cmd_r;
  logic [7:0]     widx_r;
  logic           mismatch_r;
  logic           native_prev_r;
  logic           err_r;
  logic           multi_en_r;
  logic [4:0]     multi_size_r;
  logic [1:0]     int_stat_r;
  logic [1:0]     int_mask_r;
  logic [15:0]    pw_r [MASB_PW_WORDS];

  logic        wr;
  logic        rd;
  logic        idle;
  logic        fin;
  logic        abrt;
  logic        go_xfer;
  logic        do_native;
  logic        do_setmax;
  logic        do_lock;
  logic        do_freeze;
  logic        do_unlock_ok;
  logic        do_unlock_bad;
  logic        do_multi;
  logic        lba_mode;
  logic [27:0] req_addr;
  logic [1:0]  int_evt;
  logic [7:0]  status_byte;
  logic [7:0]  error_byte;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  function automatic logic size_ok(input logic [7:0] n);
    return n == 8'h00 || n == 8'h02 || n == 8'h04 || n == 8'h08 || n == 8'h10;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return addr[1:0] == 2'h0 && addr <= MASB_OFF_SECSTATE;
  endfunction

  // zero-wait slave: every access completes in its access phase
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
  assign wr      = PSEL & PENABLE & PWRITE & mapped(PADDR);
  assign rd      = PSEL & ~PWRITE;
  assign idle    = state_r == MASB_IDLE;
  assign IRQ     = |(int_stat_r & int_mask_r);

  assign lba_mode = tf_r.devhead[MASB_DH_LBA_BIT];
  assign req_addr = {tf_r.devhead[3:0], tf_r.cylhi, tf_r.cyllo, tf_r.secnum};

  // command decode: exec decides, fin closes data-phase subcommands
  always_comb begin
    fin           = 1'b0;
    abrt          = 1'b0;
    go_xfer       = 1'b0;
    do_native     = 1'b0;
    do_setmax     = 1'b0;
    do_lock       = 1'b0;
    do_freeze     = 1'b0;
    do_unlock_ok  = 1'b0;
    do_unlock_bad = 1'b0;
    do_multi      = 1'b0;
    if (state_r == MASB_EXEC) begin
      fin = 1'b1;
      unique case (cmd_r)
        MASB_CMD_NATIVE: begin
          do_native = 1'b1;
        end
        MASB_CMD_SETMAX: begin
          if (native_prev_r) begin
            // range check only possible for LBA requests
            abrt      = sec_r.locked | sec_r.frozen |
                        (lba_mode & (req_addr > MASB_NATIVE_MAX));
            do_setmax = ~abrt;
          end else begin
            unique case (tf_r.feature)
              MASB_FT_PASSWORD: begin
                abrt    = sec_r.locked | sec_r.frozen;
                go_xfer = ~abrt;
              end
              MASB_FT_LOCK: begin
                abrt    = sec_r.locked | sec_r.frozen;
                do_lock = ~abrt;
              end
              MASB_FT_UNLOCK: begin
                abrt    = sec_r.frozen | (sec_r.tries == 3'h0);
                go_xfer = ~abrt;
              end
              MASB_FT_FREEZE: begin
                do_freeze = 1'b1;
              end
              default: begin
                abrt = 1'b1;
              end
            endcase
            // data-phase subcommands report in their final cycle instead
            fin = ~go_xfer;
          end
        end
        MASB_CMD_SETMULTI: begin
          do_multi = 1'b1;
          abrt     = ~size_ok(tf_r.seccnt);
        end
        default: begin
          abrt = 1'b1;
        end
      endcase
    end else if (state_r == MASB_FIN) begin
      fin = 1'b1;
      if (cmd_r == MASB_CMD_SETMAX && tf_r.feature == MASB_FT_UNLOCK) begin
        abrt          = mismatch_r;
        do_unlock_bad = mismatch_r;
        do_unlock_ok  = ~mismatch_r;
      end
    end
  end

  // sequencing
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= MASB_IDLE;
    end else begin
      unique case (state_r)
        MASB_IDLE: begin
          if (wr && hit(PADDR, MASB_OFF_COMMAND)) begin
            state_r <= MASB_EXEC;
          end
        end
        MASB_EXEC: begin
          state_r <= go_xfer ? MASB_XFER : MASB_IDLE;
        end
        MASB_XFER: begin
          // every word counts towards the length, reserved ones too
          if (wr && hit(PADDR, MASB_OFF_DATA) && widx_r == MASB_SECTOR_WORDS) begin
            state_r <= MASB_FIN;
          end
        end
        MASB_FIN: begin
          state_r <= MASB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cmd_r <= 8'h00;
    end else if (idle && wr && hit(PADDR, MASB_OFF_COMMAND)) begin
      cmd_r <= PWDATA[7:0];
    end
  end

  // a command counts as following read-native only if nothing came between
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      native_prev_r <= 1'b0;
    end else if (fin) begin
      native_prev_r <= do_native;
    end
  end

  // sector data phase
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      widx_r     <= 8'h00;
      mismatch_r <= 1'b0;
    end else if (go_xfer) begin
      widx_r     <= 8'h00;
      mismatch_r <= 1'b0;
    end else if (state_r == MASB_XFER && wr && hit(PADDR, MASB_OFF_DATA)) begin
      widx_r <= widx_r + 8'h01;
      if (widx_r >= MASB_PW_FIRST && widx_r <= MASB_PW_LAST &&
          PWDATA[15:0] != pw_r[4'(widx_r - 8'h01)]) begin
        mismatch_r <= 1'b1;
      end
    end
  end

  // password store; reserved words of the sector are dropped
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < MASB_PW_WORDS; i++) begin
        pw_r[i] <= 16'h0000;
      end
    end else if (state_r == MASB_XFER && wr && hit(PADDR, MASB_OFF_DATA) &&
                 tf_r.feature == MASB_FT_PASSWORD &&
                 widx_r >= MASB_PW_FIRST && widx_r <= MASB_PW_LAST) begin
      pw_r[4'(widx_r - 8'h01)] <= PWDATA[15:0];
    end
  end

  // security state; reset stands in for power cycle and hard reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sec_r <= '{frozen: 1'b0, locked: 1'b0, tries: MASB_UNLOCK_TRIES};
    end else begin
      if (state_r == MASB_FIN && tf_r.feature == MASB_FT_PASSWORD) begin
        sec_r.locked <= 1'b0;
      end
      if (do_lock) begin
        sec_r.locked <= 1'b1;
      end
      if (do_freeze) begin
        sec_r.frozen <= 1'b1;
        sec_r.locked <= 1'b0;
      end
      if (do_unlock_ok) begin
        // a good password does not give back spent attempts
        sec_r.locked <= 1'b0;
      end
      if (do_unlock_bad) begin
        sec_r.tries <= sec_r.tries - 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      multi_en_r   <= 1'b0;
      multi_size_r <= 5'h00;
    end else if (do_multi) begin
      // invalid size falls back to disabled
      multi_en_r   <= ~abrt && tf_r.seccnt != 8'h00;
      multi_size_r <= abrt ? 5'h00 : tf_r.seccnt[4:0];
    end
  end

  // task file: host writes while idle, device returns max address
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tf_r <= '0;
    end else if (do_native || do_setmax) begin
      // both modes report the same split; CHS reads it as sector/cyl/head
      tf_r.secnum       <= do_native ? MASB_NATIVE_MAX[7:0]   : req_addr[7:0];
      tf_r.cyllo        <= do_native ? MASB_NATIVE_MAX[15:8]  : req_addr[15:8];
      tf_r.cylhi        <= do_native ? MASB_NATIVE_MAX[23:16] : req_addr[23:16];
      tf_r.devhead[3:0] <= do_native ? MASB_NATIVE_MAX[27:24] : req_addr[27:24];
    end else if (idle && wr) begin
      // busy or data phase: task-file writes are dropped
      unique case (PADDR)
        MASB_OFF_FEATURE: tf_r.feature <= PWDATA[7:0];
        MASB_OFF_SECCNT:  tf_r.seccnt  <= PWDATA[7:0];
        MASB_OFF_SECNUM:  tf_r.secnum  <= PWDATA[7:0];
        MASB_OFF_CYLLO:   tf_r.cyllo   <= PWDATA[7:0];
        MASB_OFF_CYLHI:   tf_r.cylhi   <= PWDATA[7:0];
        MASB_OFF_DEVHEAD: tf_r.devhead <= PWDATA[7:0];
        default: begin
        end
      endcase
    end
  end

  // error stands until the next command starts executing
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      err_r <= 1'b0;
    end else if (fin) begin
      err_r <= abrt;
    end else if (state_r == MASB_EXEC) begin
      err_r <= 1'b0;
    end
  end

  // status and error bytes placed by the package bit positions
  always_comb begin
    status_byte                    = 8'h00;
    status_byte[MASB_ST_BUSY_BIT]  = state_r == MASB_EXEC || state_r == MASB_FIN;
    status_byte[MASB_ST_READY_BIT] = 1'b1;
    status_byte[MASB_ST_DRQ_BIT]   = state_r == MASB_XFER;
    status_byte[MASB_ST_ERR_BIT]   = err_r;
  end

  always_comb begin
    error_byte                     = 8'h00;
    error_byte[MASB_ERR_ABORT_BIT] = err_r;
  end

  // completion and abort events for the sticky status
  always_comb begin
    int_evt                     = 2'h0;
    int_evt[MASB_INT_DONE_BIT]  = fin;
    int_evt[MASB_INT_ABORT_BIT] = fin & abrt;
  end

  // sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      int_stat_r <= MASB_INT_RESET;
      int_mask_r <= MASB_INT_RESET;
    end else begin
      if (wr && hit(PADDR, MASB_OFF_INTMASK)) begin
        int_mask_r <= PWDATA[1:0];
      end
      int_stat_r <= (int_stat_r & ~((wr && hit(PADDR, MASB_OFF_INTSTAT)) ? PWDATA[1:0] : 2'h0))
                    | int_evt;
    end
  end

  // loaded in the setup cycle so it stands through the access phase
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd && !PENABLE) begin
      unique case (PADDR)
        MASB_OFF_FEATURE:  PRDATA <= {24'h0, tf_r.feature};
        MASB_OFF_SECCNT:   PRDATA <= {24'h0, tf_r.seccnt};
        MASB_OFF_SECNUM:   PRDATA <= {24'h0, tf_r.secnum};
        MASB_OFF_CYLLO:    PRDATA <= {24'h0, tf_r.cyllo};
        MASB_OFF_CYLHI:    PRDATA <= {24'h0, tf_r.cylhi};
        MASB_OFF_DEVHEAD:  PRDATA <= {24'h0, tf_r.devhead};
        MASB_OFF_COMMAND:  PRDATA <= {24'h0, cmd_r};
        MASB_OFF_ERROR:    PRDATA <= {24'h0, error_byte};
        MASB_OFF_STATUS:   PRDATA <= {24'h0, status_byte};
        MASB_OFF_INTSTAT:  PRDATA <= {30'h0, int_stat_r};
        MASB_OFF_INTMASK:  PRDATA <= {30'h0, int_mask_r};
        MASB_OFF_MULTI:    PRDATA <= {26'h0, multi_en_r, multi_size_r};
        MASB_OFF_SECSTATE: PRDATA <= {27'h0, sec_r};
        default:           PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== verif/masb_top_sva.sv ====
`timescale 1ns/1ps
module masb_top_sva
  import masb_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // interrupt
  input wire logic        IRQ
);
  logic       rd_acc;
  logic [1:0] mask_r;
  logic [2:0] tries_r;
  logic       frozen_r;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // shadows of what software has seen, so later reads can be judged
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mask_r <= 2'h0;
      tries_r <= MASB_UNLOCK_TRIES;
      frozen_r <= 1'b0;
    end else begin
      if (PSEL && PENABLE && PWRITE && PADDR == MASB_OFF_INTMASK) mask_r <= PWDATA[1:0];
      if (rd_acc && PADDR == MASB_OFF_SECSTATE) tries_r <= PRDATA[2:0];
      if (rd_acc && PADDR == MASB_OFF_SECSTATE && PRDATA[4]) frozen_r <= 1'b1;
    end
  end
  a_status_ready: assert property (rd_acc && PADDR == MASB_OFF_STATUS
    |-> PRDATA[MASB_ST_READY_BIT]) else $error("ready bit low");
  a_error_abort_only: assert property (
    rd_acc && PADDR == MASB_OFF_ERROR |-> (PRDATA & ~32'h4) == 32'h0) else $error("error bits");
  a_multi_size_legal: assert property (rd_acc && PADDR == MASB_OFF_MULTI |->
    PRDATA[4:0] inside {5'h00, 5'h02, 5'h04, 5'h08, 5'h10}) else $error("block size");
  a_multi_enable_match: assert property (rd_acc && PADDR == MASB_OFF_MULTI |->
    PRDATA[5] == (PRDATA[4:0] != 5'h0)) else $error("multiple enable");
  a_tries_no_rise: assert property (rd_acc && PADDR == MASB_OFF_SECSTATE |->
    PRDATA[2:0] <= tries_r) else $error("tries rose");
  a_frozen_sticky: assert property (rd_acc && PADDR == MASB_OFF_SECSTATE && frozen_r |->
    PRDATA[4] && !PRDATA[3]) else $error("frozen lost");
  a_bad_addr_error: assert property (PSEL && PENABLE |->
    PSLVERR == (PADDR > MASB_OFF_SECSTATE || PADDR[1:0] != 2'h0)) else $error("slverr");
  a_irq_masked: assert property (mask_r == 2'h0 |-> !IRQ) else $error("irq while masked");
endmodule

// ==== verif/masb_host_model.sv ====
`timescale 1ns/1ps
module masb_host_model
  import masb_pkg::*;
(
  // apb master
  input  wire logic        mclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale values must not look live
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic send_sector(input logic [15:0] key);
    logic [31:0] q;
    logic        e;
    for (int i = 0; i <= 255; i++) begin
      xfer(1'b1, MASB_OFF_DATA, {16'h0, (i >= 1 && i <= 16) ? key ^ 16'(i) : 16'(i)}, q, e);
    end
  endtask
endmodule

// ==== verif/masb_tb_top.sv ====
`timescale 1ns/1ps
module masb_tb_top;
  import masb_pkg::*;
  logic        MCLK;
  logic        RST;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        e, ok;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [7:0]  sz [8] = '{8'h10, 8'h03, 8'h02, 8'h20, 8'h04, 8'h08, 8'h01, 8'h00};
  logic [7:0]  bad [3] = '{8'h00, 8'h05, 8'hff};
  localparam logic [15:0] KA = 16'h5a3c;
  localparam logic [15:0] KB = 16'h1234;
  masb_top masb_top_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
  masb_host_model masb_host_model_i (.mclk(MCLK), .prdata(PRDATA), .pready(PREADY),
    .pslverr(PSLVERR), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA));
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    masb_host_model_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    masb_host_model_i.xfer(1'b0, a, 32'h0, q, e);
    check($sformatf("reg %h", a), q, x);
  endtask
  task automatic tf(input logic [27:0] v);
    rchk(MASB_OFF_SECNUM, {24'h0, v[7:0]});
    rchk(MASB_OFF_CYLLO, {24'h0, v[15:8]});
    rchk(MASB_OFF_CYLHI, {24'h0, v[23:16]});
    masb_host_model_i.xfer(1'b0, MASB_OFF_DEVHEAD, 32'h0, q, e);
    check("head field", {28'h0, q[3:0]}, {28'h0, v[27:24]});
  endtask
  task automatic tfw(input logic [7:0] dh, input logic [23:0] v);
    wr(MASB_OFF_SECNUM, {24'h0, v[7:0]});
    wr(MASB_OFF_CYLLO, {24'h0, v[15:8]});
    wr(MASB_OFF_CYLHI, {24'h0, v[23:16]});
    wr(MASB_OFF_DEVHEAD, {24'h0, dh});
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] op, input logic [15:0] k,
                     input logic ab);
    logic [31:0] st;
    wr(MASB_OFF_FEATURE, {24'h0, f});
    wr(MASB_OFF_COMMAND, {24'h0, op});
    do masb_host_model_i.xfer(1'b0, MASB_OFF_STATUS, 32'h0, st, e);
    while (st[MASB_ST_BUSY_BIT] !== 1'b0);
    if (st[MASB_ST_DRQ_BIT] === 1'b1) begin
      masb_host_model_i.send_sector(k);
      do masb_host_model_i.xfer(1'b0, MASB_OFF_STATUS, 32'h0, st, e);
      while (st[MASB_ST_BUSY_BIT] !== 1'b0 || st[MASB_ST_DRQ_BIT] !== 1'b0);
    end
    check("status err", {31'h0, st[MASB_ST_ERR_BIT]}, {31'h0, ab});
    rchk(MASB_OFF_ERROR, ab ? 32'h4 : 32'h0);
  endtask
  task do_reset;
    RST <= 1'b1;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
  endtask
  initial begin
    RST = 1'b1;
    do_reset();
    rchk(MASB_OFF_SECSTATE, 32'h5);
    wr(MASB_OFF_SECCNT, 32'h0);
    cmd(8'h00, MASB_CMD_SETMULTI, KA, 1'b0);
    rchk(MASB_OFF_INTSTAT, 32'h1);
    check("irq", {31'h0, IRQ}, 32'h0);
    wr(MASB_OFF_INTMASK, 32'h3);
    @(negedge MCLK);
    check("irq", {31'h0, IRQ}, 32'h1);
    wr(MASB_OFF_INTSTAT, 32'h3);
    @(negedge MCLK);
    check("irq", {31'h0, IRQ}, 32'h0);
    masb_host_model_i.xfer(1'b0, 8'h3c, 32'h0, q, e);
    check("slverr", {31'h0, e}, 32'h1);
    foreach (sz[i]) begin
      ok = sz[i] inside {8'h00, 8'h02, 8'h04, 8'h08, 8'h10};
      wr(MASB_OFF_SECCNT, {24'h0, sz[i]});
      cmd(8'h00, MASB_CMD_SETMULTI, KA, !ok);
      rchk(MASB_OFF_MULTI, ok ? {26'h0, sz[i] != 8'h0, sz[i][4:0]} : 32'h0);
    end
    rchk(MASB_OFF_INTSTAT, 32'h3);
    foreach (bad[j]) cmd(bad[j], MASB_CMD_SETMAX, KA, 1'b1);
    cmd(8'h00, MASB_CMD_NATIVE, KA, 1'b0);
    tf(MASB_NATIVE_MAX);
    tfw(8'h41, 24'h234567);
    cmd(MASB_FT_LOCK, MASB_CMD_SETMAX, KA, 1'b0);
    tf(28'h1234567);
    rchk(MASB_OFF_SECSTATE, 32'h5);
    cmd(8'h00, MASB_CMD_NATIVE, KA, 1'b0);
    tfw(8'h4f, 24'hffffff);
    cmd(8'h00, MASB_CMD_SETMAX, KA, 1'b1);
    cmd(8'h00, MASB_CMD_NATIVE, KA, 1'b0);
    tfw(8'h03, 24'h332211);
    cmd(MASB_FT_UNLOCK, MASB_CMD_SETMAX, KB, 1'b0);
    tf(28'h3332211);
    cmd(MASB_FT_PASSWORD, MASB_CMD_SETMAX, KA, 1'b0);
    rchk(MASB_OFF_SECSTATE, 32'h5);
    cmd(MASB_FT_LOCK, MASB_CMD_SETMAX, KA, 1'b0);
    rchk(MASB_OFF_SECSTATE, 32'h0d);
    cmd(MASB_FT_PASSWORD, MASB_CMD_SETMAX, KB, 1'b1);
    cmd(MASB_FT_UNLOCK, MASB_CMD_SETMAX, KB, 1'b1);
    rchk(MASB_OFF_SECSTATE, 32'h0c);
    cmd(MASB_FT_UNLOCK, MASB_CMD_SETMAX, KA, 1'b0);
    rchk(MASB_OFF_SECSTATE, 32'h04);
    cmd(MASB_FT_LOCK, MASB_CMD_SETMAX, KA, 1'b0);
    repeat (4) cmd(MASB_FT_UNLOCK, MASB_CMD_SETMAX, KB, 1'b1);
    cmd(MASB_FT_UNLOCK, MASB_CMD_SETMAX, KA, 1'b1);
    rchk(MASB_OFF_SECSTATE, 32'h08);
    cmd(MASB_FT_FREEZE, MASB_CMD_SETMAX, KA, 1'b0);
    rchk(MASB_OFF_SECSTATE, 32'h10);
    for (int f = 1; f <= 3; f++) cmd(8'(f), MASB_CMD_SETMAX, KA, 1'b1);
    cmd(8'h00, MASB_CMD_NATIVE, KA, 1'b0);
    cmd(8'h00, MASB_CMD_SETMAX, KA, 1'b1);
    do_reset();
    rchk(MASB_OFF_SECSTATE, 32'h5);
    finish_test();
  end
endmodule
bind masb_top masb_top_sva masb_top_sva_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
